//--- shared/lan_trig_pkg.sv
// Constants for the LAN trigger packet engine.
package lan_trig_pkg;
  // ---------------------------------------------------------------
  // Transport
  // ---------------------------------------------------------------
  localparam logic [15:0] UDP_PORT = 16'h13B4;
  localparam logic [31:0] MCAST_IP = 32'hE000179F;
  // ---------------------------------------------------------------
  // Packet layout (byte offsets in the UDP payload)
  // ---------------------------------------------------------------
  localparam logic [7:0] MARK_B0 = 8'h4C;
  localparam logic [7:0] MARK_B1 = 8'h58;
  localparam logic [7:0] VER_RST = 8'h49;
  localparam logic [10:0] F_DOM = 11'h003;
  localparam logic [10:0] F_NAME = 11'h004;
  localparam logic [10:0] F_SEQ = 11'h014;
  localparam logic [10:0] F_TS = 11'h018;
  localparam logic [10:0] F_EPOCH = 11'h020;
  localparam logic [10:0] F_FLAGS = 11'h022;
  localparam logic [10:0] HDR_LEN = 11'h024;
  localparam logic [10:0] NAME_END = 11'h013;
  localparam logic [10:0] MAX_DATA = 11'h59C;
  localparam logic [7:0] FLAG_RESEND = 8'h01;
  localparam logic [7:0] DOM_RST = 8'h00;
  // ---------------------------------------------------------------
  // Default event names
  // ---------------------------------------------------------------
  localparam logic [31:0] NAME_RST = 32'h004E414C;
  localparam logic [7:0] DIGIT_0 = 8'h30;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_DOMAIN = 12'h004;
  localparam logic [11:0] A_VERSION = 12'h008;
  localparam logic [11:0] A_DLEN = 12'h00C;
  localparam logic [11:0] A_TXCMD = 12'h010;
  localparam logic [11:0] A_STATUS = 12'h014;
  localparam logic [11:0] A_SEQ = 12'h018;
  localparam logic [11:0] A_RXHIT = 12'h01C;
  localparam logic [11:0] A_NAME = 12'h100;
  // ---------------------------------------------------------------
  // Control and transmit-command field positions
  // ---------------------------------------------------------------
  localparam int C_ARM = 0;
  localparam int C_LSEL = 2;
  localparam int C_AIEV = 4;
  localparam int C_AOEV = 8;
  localparam int C_TXEN = 16;
  localparam int T_RESEND = 8;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage

//--- rtl/lan_trigger_packet_engine.sv
// LAN trigger packet engine: builds, sends, receives and checks packets.
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Multicast UDP on fixed port and group
// - Only the multicast datagram path exists
// - Packets open with the LXI marker
// - Third marker byte is a version code
// - Domain is one unsigned byte, reset zero
// - Domain must match between both ends
// - Name field is first sixteen name bytes
// - Names reset to LAN0 through LAN7
// - Event names must match between ends
// - Sequence counts up per new packet
// - Resent copy keeps the original sequence
// - Received time stamp is ignored
// - Sent time stamp is zero
// - Sent epoch is zero
// - Flags are generated internally
// - Variable data area, capped by capacity
// - Eight events selectable as AI/AO start
// - Start on first sample after reception
module lan_trigger_packet_engine
  import lan_trig_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic [15:0] o_udp_port,
  output logic [31:0] o_mcast_ip,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic i_rx_udp,
  input wire logic [15:0] i_rx_port,
  input wire logic [31:0] i_rx_ip,
  input wire logic i_sample_tick,
  output logic o_ai_start,
  output logic o_ao_start
);
  // ---------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------
  logic [127:0] name_r [8];
  logic [31:0] ctrl_r;
  logic [1:0] arm_r;
  logic [7:0] domain_r;
  logic [7:0] version_r;
  logic [10:0] dlen_r;
  logic [31:0] seq_r;
  logic [31:0] last_seq_r;
  logic [7:0] hit_cnt_r;
  logic [2:0] hit_ev_r;
  logic [1:0] pend_r;
  logic [1:0] start_r;
  // Byte k of a stored event name.
  function automatic logic [7:0] name_byte(input logic [127:0] n,
                                           input logic [3:0] k);
    name_byte = n[{k, 3'b000} +: 8];
  endfunction
  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ---------------------------------------------------------------
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic addr_ok;
  logic wr_en;
  logic cmd_go;
  logic [31:0] rd_mux;
  assign addr_ok = i_hsel & i_htrans[1] & i_hready;
  assign wr_en = wr_pend_r;
  assign cmd_go = wr_en & (wr_addr_r == A_TXCMD);
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_r;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ok & i_hwrite;
      wr_addr_r <= i_haddr[11:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_r <= 32'h00000000;
    end else if (addr_ok & ~i_hwrite) begin
      rdata_r <= rd_mux;
    end
  end
  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_r <= 32'h00000000;
      domain_r <= DOM_RST;
      version_r <= VER_RST;
      dlen_r <= 11'h000;
    end else if (wr_en) begin
      case (wr_addr_r)
        A_CTRL: ctrl_r <= i_hwdata;
        A_DOMAIN: domain_r <= i_hwdata[7:0];
        A_VERSION: version_r <= i_hwdata[7:0];
        // Lengths above MAX_DATA in the low eleven bits are clipped to it; upper bits are dropped.
        A_DLEN: dlen_r <= (i_hwdata[10:0] > MAX_DATA) ? MAX_DATA
                                                      : i_hwdata[10:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      for (int e = 0; e < 8; e++) begin
        name_r[e] <= {96'h0, DIGIT_0 + 8'(e), NAME_RST[23:0]};
      end
    end else if (wr_en && wr_addr_r[11:8] == A_NAME[11:8] && !wr_addr_r[7]) begin
      name_r[wr_addr_r[6:4]][{wr_addr_r[3:2], 5'b00000} +: 32] <= i_hwdata;
    end
  end
  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  logic busy;
  always_comb begin
    rd_mux = 32'h00000000;
    if (i_haddr[11:8] == A_NAME[11:8]) begin
      if (!i_haddr[7]) begin
        rd_mux = name_r[i_haddr[6:4]][{i_haddr[3:2], 5'b00000} +: 32];
      end
    end else begin
      case (i_haddr[11:0])
        A_CTRL: rd_mux = {ctrl_r[31:2], arm_r};
        A_DOMAIN: rd_mux = {24'h000000, domain_r};
        A_VERSION: rd_mux = {24'h000000, version_r};
        A_DLEN: rd_mux = {21'h000000, dlen_r};
        A_STATUS: rd_mux = {28'h0000000, start_r[0], pend_r, busy};
        A_SEQ: rd_mux = last_seq_r;
        A_RXHIT: rd_mux = {21'h000000, hit_ev_r, hit_cnt_r};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Transmit serialiser
  // ---------------------------------------------------------------
  tx_state_t st_r;
  logic [10:0] idx_r;
  logic [10:0] total_r;
  logic [2:0] tx_ev_r;
  logic [31:0] tx_seq_r;
  logic [7:0] tx_flags_r;
  logic val_r;
  logic [7:0] dat_r;
  logic last_r;
  logic go_ok;
  logic [2:0] cmd_ev;
  logic cmd_resend;
  assign cmd_ev = i_hwdata[2:0];
  assign cmd_resend = i_hwdata[T_RESEND];
  // A command for an event that is not enabled, or while busy, is ignored.
  assign go_ok = cmd_go & (st_r == TX_IDLE) & ctrl_r[C_TXEN + 32'(cmd_ev)];
  assign busy = (st_r == TX_SEND);
  // Payload byte at position i.
  function automatic logic [7:0] tx_byte(input logic [10:0] i,
                                         input logic [127:0] n,
                                         input logic [31:0] sq,
                                         input logic [7:0] dom,
                                         input logic [7:0] ver,
                                         input logic [7:0] flg);
    logic [1:0] sb;
    sb = 2'(i - F_SEQ);
    tx_byte = 8'h00;
    if (i == 11'h000) begin
      tx_byte = MARK_B0;
    end else if (i == 11'h001) begin
      tx_byte = MARK_B1;
    end else if (i == 11'h002) begin
      tx_byte = ver;
    end else if (i == F_DOM) begin
      tx_byte = dom;
    end else if (i >= F_NAME && i < F_SEQ) begin
      tx_byte = name_byte(n, 4'(i - F_NAME));
    end else if (i >= F_SEQ && i < F_TS) begin
      tx_byte = sq[{~sb, 3'b000} +: 8];
    end else if (i == F_FLAGS + 11'h001) begin
      tx_byte = flg;
    end
    // Time stamp, epoch, upper flags byte and data area send zero.
  endfunction
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_r <= TX_IDLE;
      idx_r <= 11'h000;
      total_r <= HDR_LEN;
      tx_ev_r <= 3'h0;
      tx_seq_r <= 32'h00000000;
      tx_flags_r <= 8'h00;
      seq_r <= 32'h00000000;
      last_seq_r <= 32'h00000000;
    end else begin
      case (st_r)
        TX_IDLE: begin
          if (go_ok) begin
            st_r <= TX_SEND;
            idx_r <= 11'h000;
            total_r <= HDR_LEN + dlen_r;
            tx_ev_r <= cmd_ev;
            if (cmd_resend) begin
              tx_seq_r <= last_seq_r;
              tx_flags_r <= FLAG_RESEND;
            end else begin
              tx_seq_r <= seq_r;
              last_seq_r <= seq_r;
              seq_r <= seq_r + 32'h00000001;
              tx_flags_r <= 8'h00;
            end
          end
        end
        TX_SEND: begin
          if (!val_r || i_tx_ready) begin
            if (idx_r < total_r) begin
              idx_r <= idx_r + 11'h001;
            end else begin
              st_r <= TX_IDLE;
            end
          end
        end
        default: st_r <= TX_IDLE;
      endcase
    end
  end
  // Output stage: a new byte is loaded whenever the old one is taken.
  // The sink may stall any byte, so the byte and its last mark hold until taken.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      val_r <= 1'b0;
      dat_r <= 8'h00;
      last_r <= 1'b0;
    end else if (!val_r || i_tx_ready) begin
      if (st_r == TX_SEND && idx_r < total_r) begin
        val_r <= 1'b1;
        dat_r <= tx_byte(idx_r, name_r[tx_ev_r], tx_seq_r, domain_r,
                         version_r, tx_flags_r);
        last_r <= (idx_r == total_r - 11'h001);
      end else begin
        val_r <= 1'b0;
        last_r <= 1'b0;
      end
    end
  end
  assign o_tx_valid = val_r;
  assign o_tx_data = dat_r;
  assign o_tx_last = last_r;
  assign o_udp_port = UDP_PORT;
  assign o_mcast_ip = MCAST_IP;
  // ---------------------------------------------------------------
  // Receive checker
  // ---------------------------------------------------------------
  logic [10:0] ridx_r;
  logic rok_r;
  logic [7:0] rhit_r;
  logic rok_nxt;
  logic [7:0] rhit_nxt;
  logic route_ok;
  logic rx_done;
  // TCP or unicast traffic never qualifies.
  assign route_ok = i_rx_udp & (i_rx_port == UDP_PORT)
                  & (i_rx_ip == MCAST_IP);
  // Every stored name is compared in parallel, so one packet may hit several events.
  always_comb begin
    rok_nxt = rok_r & route_ok;
    rhit_nxt = rhit_r;
    if (ridx_r == 11'h000) begin
      rok_nxt = route_ok & (i_rx_data == MARK_B0);
      rhit_nxt = 8'hFF;
    end else if (ridx_r == 11'h001) begin
      rok_nxt = rok_nxt & (i_rx_data == MARK_B1);
    end else if (ridx_r == 11'h002) begin
      rok_nxt = rok_nxt & (i_rx_data == version_r);
    end else if (ridx_r == F_DOM) begin
      rok_nxt = rok_nxt & (i_rx_data == domain_r);
    end else if (ridx_r >= F_NAME && ridx_r <= NAME_END) begin
      for (int e = 0; e < 8; e++) begin
        rhit_nxt[e] = rhit_r[e]
                    & (name_byte(name_r[e], 4'(ridx_r - F_NAME)) == i_rx_data);
      end
    end
    // Bytes past the name, the time stamp among them, are not examined.
  end
  // A runt that ends before the name is complete is dropped.
  assign rx_done = i_rx_valid & i_rx_last & rok_nxt
                 & (ridx_r >= NAME_END);
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ridx_r <= 11'h000;
      rok_r <= 1'b0;
      rhit_r <= 8'h00;
    end else if (i_rx_valid) begin
      if (i_rx_last) begin
        ridx_r <= 11'h000;
      end else if (ridx_r != 11'h7FF) begin
        ridx_r <= ridx_r + 11'h001;
      end
      rok_r <= rok_nxt;
      rhit_r <= rhit_nxt;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hit_cnt_r <= 8'h00;
      hit_ev_r <= 3'h0;
    end else if (rx_done && rhit_nxt != 8'h00) begin
      // The lowest matching event is the one reported.
      hit_cnt_r <= hit_cnt_r + 8'h01;
      for (int e = 7; e >= 0; e--) begin
        if (rhit_nxt[e]) begin
          hit_ev_r <= 3'(e);
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Start logic for analog input (0) and analog output (1)
  // ---------------------------------------------------------------
  logic ctrl_wr;
  assign ctrl_wr = wr_en & (wr_addr_r == A_CTRL);
  for (genvar s = 0; s < 2; s++) begin : g_sub
    logic [2:0] ev;
    assign ev = (s == 0) ? ctrl_r[C_AIEV +: 3] : ctrl_r[C_AOEV +: 3];
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        arm_r[s] <= 1'b0;
        pend_r[s] <= 1'b0;
        start_r[s] <= 1'b0;
      end else begin
        start_r[s] <= pend_r[s] & i_sample_tick;
        if (ctrl_wr) begin
          // Software is expected to set source and event before arming.
          arm_r[s] <= i_hwdata[C_ARM + s];
          pend_r[s] <= 1'b0;
        end else if (pend_r[s] && i_sample_tick) begin
          arm_r[s] <= 1'b0;
          pend_r[s] <= 1'b0;
        end else if (rx_done && arm_r[s] && ctrl_r[C_LSEL + s] && rhit_nxt[ev]) begin
          pend_r[s] <= 1'b1;
        end
      end
    end
  end
  assign o_ai_start = start_r[0];
  assign o_ao_start = start_r[1];
endmodule // lan_trigger_packet_engine
`default_nettype wire

//--- bench/lan_trig_assertions.sv
// Port-level assertions for the LAN trigger packet engine.
`timescale 1ns/1ns
`default_nettype none
module lan_trig_assertions (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_tx_ready,
  input wire logic i_sample_tick,
  input wire logic [15:0] o_udp_port,
  input wire logic [31:0] o_mcast_ip,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_last,
  input wire logic o_ai_start,
  input wire logic o_ao_start
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ---------------------------------------------------------------
  // Helper: bytes accepted so far in the current packet
  // ---------------------------------------------------------------
  logic [10:0] pos_r;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) pos_r <= 11'h000;
    else if (o_tx_valid && i_tx_ready) pos_r <= o_tx_last ? 11'h000 : pos_r + 11'h001;
  end
  a_port_fixed: assert property (o_udp_port == 16'h13B4)
    else $error("udp port is not the fixed trigger port");
  a_group_fixed: assert property (o_mcast_ip == 32'hE000179F)
    else $error("multicast group is not the fixed address");
  a_marker_lead: assert property ($rose(o_tx_valid) |-> o_tx_data == 8'h4C)
    else $error("packet does not open with the marker");
  a_byte_hold: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last)) else $error("byte changed unaccepted");
  a_last_ends: assert property (o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
    else $error("stream continued after last byte");
  a_min_len: assert property (o_tx_valid && o_tx_last |-> pos_r >= 11'h023)
    else $error("packet shorter than the header");
  a_ai_tick: assert property (o_ai_start |-> $past(i_sample_tick))
    else $error("input start not after a sample tick");
  a_ao_tick: assert property (o_ao_start |-> $past(i_sample_tick))
    else $error("output start not after a sample tick");
  a_ai_single: assert property (o_ai_start |=> !o_ai_start)
    else $error("input start longer than one cycle");
  a_ao_single: assert property (o_ao_start |=> !o_ao_start)
    else $error("output start longer than one cycle");
endmodule // lan_trig_assertions
bind lan_trigger_packet_engine lan_trig_assertions u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_tx_ready(i_tx_ready), .i_sample_tick(i_sample_tick), .o_udp_port(o_udp_port),
  .o_mcast_ip(o_mcast_ip), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
  .o_tx_last(o_tx_last), .o_ai_start(o_ai_start), .o_ao_start(o_ao_start));
`default_nettype wire

//--- bench/lan_peer_model.sv
// Network peer model: feeds received payloads and sinks sent bytes.
`timescale 1ns/1ns
`default_nettype none
module lan_peer_model
  import lan_trig_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_stall,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_last,
  output logic o_rx_udp,
  output logic [15:0] o_rx_port,
  output logic [31:0] o_rx_ip,
  output logic o_tx_ready
);
  typedef logic [7:0] pbytes_t[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_last = 1'b0;
    o_rx_udp = 1'b1;
    o_rx_port = UDP_PORT;
    o_rx_ip = MCAST_IP;
    o_tx_ready = 1'b0;
  end
  // A stalling sink is ready on every other cycle, like a congested stack.
  always @(posedge i_clk) o_tx_ready <= i_stall ? ~o_tx_ready : 1'b1;
  task automatic send(input pbytes_t q, input logic udp, input logic [15:0] port);
    o_rx_udp <= udp;
    o_rx_port <= port;
    o_rx_ip <= MCAST_IP;
    foreach (q[i]) begin
      o_rx_valid <= 1'b1;
      o_rx_data <= q[i];
      o_rx_last <= (i == q.size() - 1);
      @(posedge i_clk);
    end
    // Idle data shows the inverse so a stale byte is never mistaken for valid.
    o_rx_valid <= 1'b0;
    o_rx_last <= 1'b0;
    o_rx_data <= ~q[q.size() - 1];
  endtask
endmodule // lan_peer_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the LAN trigger packet engine.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import lan_trig_pkg::*;
;
  typedef logic [7:0] bq_t[$];
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, tick = 1'b0, stall = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire hrdy, hresp, txv, txl, txr, rxv, rxl, rxu, ai, ao;
  wire [7:0] txd, rxd;
  wire [15:0] rxp;
  wire [31:0] rxip, hrdata;
  int miscompares = 0, n_tests = 0, n_pkts = 0, n_ai = 0, n_ao = 0, cyc = 0;
  bq_t txq, q;
  always #4 i_clk = ~i_clk;
  lan_trigger_packet_engine dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
    .o_hrdata(hrdata), .o_udp_port(), .o_mcast_ip(), .o_tx_valid(txv), .o_tx_data(txd),
    .o_tx_last(txl), .i_tx_ready(txr), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_last(rxl),
    .i_rx_udp(rxu), .i_rx_port(rxp), .i_rx_ip(rxip), .i_sample_tick(tick),
    .o_ai_start(ai), .o_ao_start(ao));
  lan_peer_model peer (.i_clk(i_clk), .i_stall(stall), .o_rx_valid(rxv), .o_rx_data(rxd),
    .o_rx_last(rxl), .o_rx_udp(rxu), .o_rx_port(rxp), .o_rx_ip(rxip), .o_tx_ready(txr));
  // ---------------------------------------------------------------
  // Monitors and hang limit
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (txv && txr) txq.push_back(txd);
    if (txv && txr && txl) n_pkts++;
    if (ai) n_ai++;
    if (ao) n_ao++;
    if (cyc == 30000) begin
      miscompares++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // The expected payload is rebuilt byte by byte in field order.
  function automatic bq_t build(input int e, input logic [7:0] dom, input logic [31:0] sq,
                               input logic [7:0] flg, input int dl, input logic [7:0] ts);
    bq_t b;
    b = '{MARK_B0, MARK_B1, VER_RST, dom, 8'h4C, 8'h41, 8'h4E, DIGIT_0 + 8'(e)};
    repeat (12) b.push_back(8'h00);
    for (int i = 3; i >= 0; i--) b.push_back(sq[8*i+:8]);
    repeat (8) b.push_back(ts);
    repeat (3) b.push_back(8'h00);
    b.push_back(flg);
    repeat (dl) b.push_back(8'h00);
    return b;
  endfunction
  task automatic sent(input int n, input bq_t exp);
    while (n_pkts < n) @(posedge i_clk);
    repeat (60) @(posedge i_clk);
    chk(32'(n_pkts), 32'(n));
    chk(32'(txq.size()), 32'(exp.size()));
    foreach (exp[i]) chk({24'h0, txq[i]}, {24'h0, exp[i]});
    txq.delete();
  endtask
  task automatic rx(input bq_t p, input logic udp, input int ea, input int eo);
    peer.send(p, udp, UDP_PORT);
    repeat (3) @(posedge i_clk);
    tick <= 1'b1;
    @(posedge i_clk);
    tick <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(32'(n_ai), 32'(ea));
    chk(32'(n_ao), 32'(eo));
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rdc(A_DOMAIN, 32'h0);
    rdc(A_VERSION, 32'h49);
    rdc(A_SEQ, 32'h0);
    rdc(12'h200, 32'h0);
    for (int e = 0; e < 8; e++) begin
      rdc(A_NAME + 12'(16 * e), {DIGIT_0 + 8'(e), NAME_RST[23:0]});
      rdc(A_NAME + 12'(16 * e + 12), 32'h0);
    end
    wr(A_CTRL, 32'h0008_0000);
    wr(A_DOMAIN, 32'h5A);
    wr(A_DLEN, 32'h2);
    rdc(A_DOMAIN, 32'h5A);
    stall <= 1'b1;
    wr(A_TXCMD, 32'h3);
    wr(A_TXCMD, 32'h3);
    rdc(A_STATUS, 32'h1);
    sent(1, build(3, 8'h5A, 0, 8'h00, 2, 8'h00));
    rdc(A_SEQ, 32'h0);
    wr(A_TXCMD, 32'h3);
    sent(2, build(3, 8'h5A, 1, 8'h00, 2, 8'h00));
    wr(A_TXCMD, 32'h103);
    sent(3, build(3, 8'h5A, 1, FLAG_RESEND, 2, 8'h00));
    rdc(A_SEQ, 32'h1);
    stall <= 1'b0;
    wr(A_DLEN, 32'h0);
    wr(A_TXCMD, 32'h4);
    wr(A_TXCMD, 32'h3);
    sent(4, build(3, 8'h5A, 2, 8'h00, 0, 8'h00));
    wr(A_CTRL, 32'h25F);
    rx(build(5, 8'h5B, 0, 8'h00, 0, 8'hA5), 1'b1, 0, 0);
    rx(build(4, 8'h5A, 0, 8'h00, 0, 8'hA5), 1'b1, 0, 0);
    q = build(5, 8'h5A, 0, 8'h00, 0, 8'hA5);
    q[0] = 8'h4D;
    rx(q, 1'b1, 0, 0);
    q[0] = MARK_B0;
    q[2] = 8'h4A;
    rx(q, 1'b1, 0, 0);
    q[2] = VER_RST;
    rx(q, 1'b0, 0, 0);
    rx(q, 1'b1, 1, 0);
    rx(build(2, 8'h5A, 7, 8'h00, 0, 8'h11), 1'b1, 1, 1);
    rx(q, 1'b1, 1, 1);
    wr(12'h15C, 32'h44434241);
    wr(A_CTRL, 32'h25F);
    rx(q, 1'b1, 1, 1);
    q[16] = 8'h41;
    q[17] = 8'h42;
    q[18] = 8'h43;
    q[19] = 8'h44;
    rx(q, 1'b1, 2, 1);
    rdc(A_RXHIT, 32'h0000_0505);
    summarize();
  end
endmodule // testbench
`default_nettype wire
